// file: pkg/wwd_defs.svh
// register map, field positions, reset values and timing counts of the window watchdog
`ifndef WWD_DEFS_SVH
`define WWD_DEFS_SVH

// register byte offsets
`define WWD_OFS_RELOAD 5'h00
`define WWD_OFS_CTRL 5'h04
`define WWD_OFS_STATUS 5'h08
`define WWD_OFS_COUNT 5'h0C
`define WWD_OFS_CLKSRC 5'h10

// control register fields
`define WWD_CTRL_EN_BIT 0
`define WWD_CTRL_IE_BIT 1
`define WWD_CTRL_PSEL_LSB 8
`define WWD_CTRL_PSEL_MSB 11
`define WWD_CTRL_WIN_LSB 16
`define WWD_CTRL_WIN_MSB 21
`define WWD_CTRL_DBG_BIT 31
`define WWD_CTRL_RESET 32'h003F_0800

// status and clock source fields
`define WWD_STAT_MATCH_BIT 0
`define WWD_CLKSRC_OSC_BIT 0

// counter and reload key
`define WWD_CNT_TOP 6'h3F
`define WWD_CNT_ZERO 6'h00
`define WWD_RELOAD_KEY 32'h0000_5AA5

// counting clock taken from the bus clock divided by this
`define WWD_HCLK_DIV 2048
// counting clocks needed to carry a reload into the counter
`define WWD_SYNC_CLKS 3

`endif

// file: pkg/wwd_pkg.sv
// types and the prescale table of the window watchdog
package wwd_pkg;

  // software settings of the control register
  typedef struct packed {
    logic dbg_keep;
    logic [5:0] window_compare_value;
    logic [3:0] psel;
    logic irq_en;
    logic count_en;
  } wwd_ctrl_t;

  // reload carry-over states
  typedef enum logic [1:0] {
    RL_IDLE = 2'b00,
    RL_W1 = 2'b01,
    RL_W2 = 2'b10,
    RL_W3 = 2'b11
  } wwd_rl_state_t;

  // prescale value minus one for each select code
  function automatic logic [10:0] wwd_presc_last(input logic [3:0] sel);
    logic [10:0] v;
    v = 11'h000;
    unique case (sel)
      4'h0: v = 11'h000;
      4'h1: v = 11'h001;
      4'h2: v = 11'h003;
      4'h3: v = 11'h007;
      4'h4: v = 11'h00F;
      4'h5: v = 11'h01F;
      4'h6: v = 11'h03F;
      4'h7: v = 11'h07F;
      4'h8: v = 11'h0BF;
      4'h9: v = 11'h0FF;
      4'hA: v = 11'h17F;
      4'hB: v = 11'h1FF;
      4'hC: v = 11'h2FF;
      4'hD: v = 11'h3FF;
      4'hE: v = 11'h5FF;
      4'hF: v = 11'h7FF;
    endcase
    return v;
  endfunction

endpackage

// file: src/wwd_prescaler.sv
// counting clock source select and prescaler of the window watchdog
`timescale 1ns/1ps
`include "wwd_defs.svh"

module wwd_prescaler #(
  parameter int DIV = `WWD_HCLK_DIV
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // source and control
  input wire logic src_osc_i,
  input wire logic osc_tick_i,
  input wire logic run_i,
  input wire logic [3:0] psel_i,
  // ticks
  output logic wclk_tick_o,
  output logic cnt_tick_o
);

  localparam int DW = $clog2(DIV);
  localparam logic [DW-1:0] DIV_LAST = DW'(DIV - 1);

  logic [DW-1:0] div_cnt;
  logic [10:0] pre_cnt;
  logic wtick;
  logic ctick;
  logic [DW-1:0] next_div_cnt;
  logic [10:0] next_pre_cnt;
  logic next_wtick;
  logic next_ctick;
  logic base_tick;

  // base tick from the bus clock divider or the oscillator pulse; gated while stopped
  always_comb begin
    next_div_cnt = (div_cnt == DIV_LAST) ? '0 : div_cnt + 1'b1;
    base_tick = run_i & (src_osc_i ? osc_tick_i : (div_cnt == DIV_LAST));
    next_wtick = base_tick;
    next_ctick = 1'b0;
    next_pre_cnt = pre_cnt;
    if (!run_i) begin
      next_pre_cnt = '0;
    end else if (base_tick) begin
      if (pre_cnt >= wwd_pkg::wwd_presc_last(psel_i)) begin
        next_pre_cnt = '0;
        next_ctick = 1'b1;
      end else begin
        next_pre_cnt = pre_cnt + 11'h001;
      end
    end
  end

  // registered ticks keep both outputs glitch free
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      div_cnt <= '0;
      pre_cnt <= '0;
      wtick <= 1'b0;
      ctick <= 1'b0;
    end else begin
      div_cnt <= next_div_cnt;
      pre_cnt <= next_pre_cnt;
      wtick <= next_wtick;
      ctick <= next_ctick;
    end
  end

  assign wclk_tick_o = wtick;
  assign cnt_tick_o = ctick;

endmodule

// file: src/wwd_top.sv
// window watchdog with a classic wishbone register slave
//
// Register access over Wishbone and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
`include "wwd_defs.svh"

module wwd_top #(
  parameter int ADDR_W = 5,
  parameter int DIV = `WWD_HCLK_DIV
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [ADDR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // clock source and debug
  input wire logic osc_tick_i,
  input wire logic dbg_halt_i,
  // watchdog outputs
  output logic irq_o,
  output logic wdt_rst_o
);

  // reset image of the control register, split into its fields at reset
  localparam logic [31:0] CTRL_RST = `WWD_CTRL_RESET;

  // bus state
  logic ack;
  logic [31:0] rdata;
  logic next_ack;
  logic [31:0] next_rdata;

  // software settings
  wwd_pkg::wwd_ctrl_t ctrl;
  wwd_pkg::wwd_ctrl_t next_ctrl;
  logic ctrl_locked;
  logic next_ctrl_locked;
  logic clk_osc;
  logic next_clk_osc;

  // counting state
  logic [5:0] cnt;
  logic [5:0] next_cnt;
  logic match_flag;
  logic next_match_flag;
  logic rst_req;
  logic next_rst_req;
  wwd_pkg::wwd_rl_state_t rl_state;
  wwd_pkg::wwd_rl_state_t next_rl_state;

  // decoded accesses and ticks
  logic wr_fire;
  logic wr_ctrl;
  logic wr_stat;
  logic wr_clksrc;
  logic key_write;
  logic in_window;
  logic run;
  logic wclk_tick;
  logic cnt_tick;
  logic rl_done;

  // registers decode on the byte offset; wider address bits must be zero
  function automatic logic hit(input logic [ADDR_W-1:0] adr, input logic [4:0] ofs);
    return (adr == ADDR_W'(ofs));
  endfunction

  // merge written byte lanes into an old value
  function automatic logic [31:0] lanes(input logic [31:0] old, input logic [31:0] dat,
                                        input logic [3:0] sel);
    logic [31:0] v;
    v = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        v[i*8 +: 8] = dat[i*8 +: 8];
      end
    end
    return v;
  endfunction

  // control word as software sees it
  function automatic logic [31:0] ctrl_word(input wwd_pkg::wwd_ctrl_t c);
    logic [31:0] w;
    w = 32'h0000_0000;
    w[`WWD_CTRL_DBG_BIT] = c.dbg_keep;
    w[`WWD_CTRL_WIN_MSB:`WWD_CTRL_WIN_LSB] = c.window_compare_value;
    w[`WWD_CTRL_PSEL_MSB:`WWD_CTRL_PSEL_LSB] = c.psel;
    w[`WWD_CTRL_IE_BIT] = c.irq_en;
    w[`WWD_CTRL_EN_BIT] = c.count_en;
    return w;
  endfunction

  // accesses take effect at the edge that samples ack, exactly once
  assign wr_fire = wb_cyc_i & wb_stb_i & wb_we_i & ack;
  assign wr_ctrl = wr_fire & hit(wb_adr_i, `WWD_OFS_CTRL);
  assign wr_stat = wr_fire & hit(wb_adr_i, `WWD_OFS_STATUS);
  assign wr_clksrc = wr_fire & hit(wb_adr_i, `WWD_OFS_CLKSRC);
  assign key_write = wr_fire & hit(wb_adr_i, `WWD_OFS_RELOAD) & (wb_dat_i == `WWD_RELOAD_KEY);
  assign in_window = (cnt <= ctrl.window_compare_value);
  // counting stops under debug halt unless software asked it to keep going
  assign run = ctrl.count_en & ~rst_req & (~dbg_halt_i | ctrl.dbg_keep);

  // counting clock and prescaler
  wwd_prescaler #(
    .DIV(DIV)
  ) u_presc (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .src_osc_i(clk_osc),
    .osc_tick_i(osc_tick_i),
    .run_i(run),
    .psel_i(ctrl.psel),
    .wclk_tick_o(wclk_tick),
    .cnt_tick_o(cnt_tick)
  );

  // bus answer: one wait state, ack drops the cycle after it was given
  always_comb begin
    next_ack = wb_cyc_i & wb_stb_i & ~ack;
    next_rdata = 32'h0000_0000;
    if (wb_cyc_i && wb_stb_i && !wb_we_i && !ack) begin
      unique case (1'b1)
        hit(wb_adr_i, `WWD_OFS_CTRL): next_rdata = ctrl_word(ctrl);
        hit(wb_adr_i, `WWD_OFS_STATUS): next_rdata[`WWD_STAT_MATCH_BIT] = match_flag;
        hit(wb_adr_i, `WWD_OFS_COUNT): next_rdata[5:0] = cnt;
        hit(wb_adr_i, `WWD_OFS_CLKSRC): next_rdata[`WWD_CLKSRC_OSC_BIT] = clk_osc;
        default: next_rdata = 32'h0000_0000; // reload and unmapped read zero
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack <= 1'b0;
      rdata <= 32'h0000_0000;
    end else begin
      ack <= next_ack;
      rdata <= next_rdata;
    end
  end

  assign wb_ack_o = ack;
  assign wb_dat_o = rdata;

  // control register: first write wins, the rest are dropped until reset
  always_comb begin
    logic [31:0] w;
    w = lanes(ctrl_word(ctrl), wb_dat_i, wb_sel_i);
    next_ctrl = ctrl;
    next_ctrl_locked = ctrl_locked;
    next_clk_osc = clk_osc;
    if (wr_ctrl && !ctrl_locked) begin
      next_ctrl.dbg_keep = w[`WWD_CTRL_DBG_BIT];
      next_ctrl.window_compare_value = w[`WWD_CTRL_WIN_MSB:`WWD_CTRL_WIN_LSB];
      next_ctrl.psel = w[`WWD_CTRL_PSEL_MSB:`WWD_CTRL_PSEL_LSB];
      next_ctrl.irq_en = w[`WWD_CTRL_IE_BIT];
      next_ctrl.count_en = w[`WWD_CTRL_EN_BIT];
      next_ctrl_locked = 1'b1;
    end
    // the source may not move under a running counter either
    if (wr_clksrc && wb_sel_i[0] && !ctrl.count_en) begin
      next_clk_osc = wb_dat_i[`WWD_CLKSRC_OSC_BIT];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl <= wwd_pkg::wwd_ctrl_t'({CTRL_RST[`WWD_CTRL_DBG_BIT], CTRL_RST[`WWD_CTRL_WIN_MSB:`WWD_CTRL_WIN_LSB],
                                    CTRL_RST[`WWD_CTRL_PSEL_MSB:`WWD_CTRL_PSEL_LSB], CTRL_RST[`WWD_CTRL_IE_BIT],
                                    CTRL_RST[`WWD_CTRL_EN_BIT]});
      ctrl_locked <= 1'b0;
      clk_osc <= 1'b0;
    end else begin
      ctrl <= next_ctrl;
      ctrl_locked <= next_ctrl_locked;
      clk_osc <= next_clk_osc;
    end
  end

  // reload carry-over: a key in the window waits three counting clocks
  always_comb begin
    next_rl_state = rl_state;
    rl_done = 1'b0;
    unique case (rl_state)
      wwd_pkg::RL_IDLE: begin
        if (key_write && ctrl.count_en && in_window) begin
          next_rl_state = wwd_pkg::RL_W1;
        end
      end
      wwd_pkg::RL_W1: begin
        if (wclk_tick) begin
          next_rl_state = wwd_pkg::RL_W2;
        end
      end
      wwd_pkg::RL_W2: begin
        if (wclk_tick) begin
          next_rl_state = wwd_pkg::RL_W3;
        end
      end
      wwd_pkg::RL_W3: begin
        if (wclk_tick) begin
          next_rl_state = wwd_pkg::RL_IDLE;
          rl_done = 1'b1;
        end
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rl_state <= wwd_pkg::RL_IDLE;
    end else begin
      rl_state <= next_rl_state;
    end
  end

  // counter, match flag and watchdog reset request
  always_comb begin
    next_cnt = cnt;
    next_match_flag = match_flag;
    next_rst_req = rst_req;
    // a reload that finishes just as a debug halt starts must not be lost
    if (rl_done) begin
      next_cnt = `WWD_CNT_TOP;
    end else if (run && cnt_tick && cnt != `WWD_CNT_ZERO) begin
      next_cnt = cnt - 6'h01;
    end
    // a too-early key resets the chip at once
    if (key_write && ctrl.count_en && !in_window) begin
      next_rst_req = 1'b1;
    end
    if (ctrl.count_en && next_cnt == `WWD_CNT_ZERO) begin
      next_rst_req = 1'b1;
    end
    // write one clears; a match in the same cycle still sets
    if (wr_stat && wb_sel_i[0] && wb_dat_i[`WWD_STAT_MATCH_BIT]) begin
      next_match_flag = 1'b0;
    end
    if (run && next_cnt != cnt && next_cnt == ctrl.window_compare_value) begin
      next_match_flag = 1'b1;
    end
  end

  // the reset request holds until the chip reset comes back around
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt <= `WWD_CNT_TOP;
      match_flag <= 1'b0;
      rst_req <= 1'b0;
    end else begin
      cnt <= next_cnt;
      match_flag <= next_match_flag;
      rst_req <= next_rst_req;
    end
  end

  // level interrupt; software drops it by clearing the flag
  assign irq_o = match_flag & ctrl.irq_en;
  assign wdt_rst_o = rst_req;

endmodule

// file: verif/wwd_top_asserts.sv
// port assertions for the window watchdog top
`timescale 1ns/1ps
`include "wwd_defs.svh"
module wwd_top_asserts #(
  parameter int ADDR_W = 5
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // wishbone
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [ADDR_W-1:0] wb_adr_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  // watchdog outputs
  input wire logic irq_o,
  input wire logic wdt_rst_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  // read answer on the bus
  logic rd_ack;
  assign rd_ack = wb_ack_o && !wb_we_i;
  // fresh request: cyc was low one cycle earlier
  sequence s_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o && !$past(wb_cyc_i);
  endsequence
  a_ack_latency: assert property (s_req |=> wb_ack_o)
    else $error("ack missing one cycle after request");
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_dat_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
    else $error("read data not zero outside ack");
  a_rst_hold: assert property (wdt_rst_o |=> wdt_rst_o)
    else $error("watchdog reset dropped before chip reset");
  a_count_width: assert property (rd_ack && wb_adr_i == `WWD_OFS_COUNT |-> wb_dat_o[31:6] == 26'h0)
    else $error("counter readback wider than six bits");
  a_reload_zero: assert property (rd_ack && wb_adr_i == `WWD_OFS_RELOAD |-> wb_dat_o == 32'h0)
    else $error("reload register read not zero");
  a_status_width: assert property (rd_ack && wb_adr_i == `WWD_OFS_STATUS |-> wb_dat_o[31:1] == 31'h0)
    else $error("status upper bits not zero");
  // the flag only leaves through a software write
  a_irq_held: assert property ($fell(irq_o) |-> $past(wb_ack_o && wb_we_i))
    else $error("interrupt dropped without a write");
endmodule

bind wwd_top wwd_top_asserts #(.ADDR_W(ADDR_W)) u_asserts (
  .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .irq_o(irq_o), .wdt_rst_o(wdt_rst_o));

// file: verif/wwd_top_bench.sv
// self-checking testbench of the window watchdog top
`timescale 1ns/1ps
`include "wwd_defs.svh"
module wwd_top_bench;
  // rows: prescale value for each select code
  int pv[16] = '{1, 2, 4, 8, 16, 32, 64, 128, 192, 256, 384, 512, 768, 1024, 1536, 2048};
  logic clk = 1'h0;
  logic rst = 1'h1;
  logic cyc = 1'h0;
  logic stb = 1'h0;
  logic we = 1'h0;
  logic [4:0] adr = 5'h00;
  logic [31:0] dat = 32'h0;
  logic osc = 1'h0;
  logic dbg = 1'h0;
  logic [31:0] rdat;
  logic ack;
  logic irq;
  logic wrst;
  logic [31:0] q;
  logic [31:0] q2;
  int cyc_n = 0;
  int el;
  int n_errors = 0;
  int compares = 0;

  // short bus-clock divider keeps the time-out run brief
  wwd_top #(.ADDR_W(5), .DIV(16)) u_dut (
    .clk_i(clk), .rst_i(rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .osc_tick_i(osc), .dbg_halt_i(dbg), .irq_o(irq), .wdt_rst_o(wrst));

  initial begin
    forever #5 clk = ~clk;
  end

  // cycle count for timing, oscillator tick every fourth cycle
  always @(posedge clk) begin
    cyc_n <= cyc_n + 1;
    osc <= (cyc_n % 4 == 3);
  end

  // one classic cycle; read data lands in q
  task automatic xfer(input logic w, input logic [4:0] a, input logic [31:0] d);
    cyc <= 1'h1;
    stb <= 1'h1;
    we <= w;
    adr <= a;
    dat <= d;
    do @(posedge clk); while (ack !== 1'h1);
    q = rdat;
    cyc <= 1'h0;
    stb <= 1'h0;
    we <= 1'h0;
    @(posedge clk);
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      n_errors++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic do_reset;
    rst <= 1'h1;
    repeat (3) @(posedge clk);
    rst <= 1'h0;
    @(posedge clk);
  endtask

  task automatic complete_run;
    $display("compares %0d n_errors %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  initial begin
    // each select code from the oscillator: time to the first step, halted but told to keep going
    dbg <= 1'h1;
    for (int i = 0; i < 16; i++) begin
      do_reset;
      xfer(1'h1, `WWD_OFS_CLKSRC, 32'h1);
      xfer(1'h0, `WWD_OFS_CLKSRC, 32'h0);
      chk("clock source", 32'h1, q);
      el = cyc_n;
      xfer(1'h1, `WWD_OFS_CTRL, {16'h803F, 4'h0, 4'(i), 8'h01});
      do xfer(1'h0, `WWD_OFS_COUNT, 32'h0); while (q[5:0] == 6'h3F);
      el = cyc_n - el;
      chk("first step", 32'h3E, q);
      chk("step time", 32'h1, el >= 4 * pv[i] - 4 && el <= 4 * pv[i] + 12);
    end
    dbg <= 1'h0;
    // bus-clock source: lock, debug halt, match, reload, time-out
    do_reset;
    xfer(1'h1, `WWD_OFS_CTRL, 32'h0020_0003);
    xfer(1'h1, `WWD_OFS_CTRL, 32'h0);
    xfer(1'h0, `WWD_OFS_CTRL, 32'h0);
    chk("ctrl", 32'h0020_0003, q);
    xfer(1'h1, `WWD_OFS_RELOAD, 32'h0000_5AA4);
    dbg <= 1'h1;
    repeat (2) @(posedge clk);
    chk("bad key", 32'h0, wrst);
    xfer(1'h0, `WWD_OFS_COUNT, 32'h0);
    q2 = q;
    repeat (64) @(posedge clk);
    xfer(1'h0, `WWD_OFS_COUNT, 32'h0);
    dbg <= 1'h0;
    chk("halted", q2, q);
    while (irq !== 1'h1) @(posedge clk);
    xfer(1'h0, `WWD_OFS_COUNT, 32'h0);
    chk("match count", 32'h20, q);
    xfer(1'h1, `WWD_OFS_STATUS, 32'h0);
    xfer(1'h0, `WWD_OFS_STATUS, 32'h0);
    chk("flag kept", 32'h1, q);
    xfer(1'h1, `WWD_OFS_STATUS, 32'h1);
    xfer(1'h0, `WWD_OFS_STATUS, 32'h0);
    chk("flag cleared", 32'h0, q);
    chk("irq", 32'h0, irq);
    xfer(1'h1, `WWD_OFS_RELOAD, `WWD_RELOAD_KEY);
    el = cyc_n;
    do xfer(1'h0, `WWD_OFS_COUNT, 32'h0); while (q[5:0] <= 6'h20);
    el = cyc_n - el;
    chk("reload", 32'h3F, q);
    chk("reload delay", 32'h1, el >= 30 && el <= 56);
    el = cyc_n;
    while (wrst !== 1'h1) @(posedge clk);
    el = cyc_n - el;
    chk("time-out", 32'h1, el >= 63 * 16 - 20 && el <= 63 * 16 + 4);
    xfer(1'h0, `WWD_OFS_COUNT, 32'h0);
    chk("zero count", 32'h0, q);
    // reset values, unmapped place, key above the window
    do_reset;
    chk("reset out", 32'h0, wrst);
    xfer(1'h0, `WWD_OFS_CTRL, 32'h0);
    chk("ctrl reset", `WWD_CTRL_RESET, q);
    xfer(1'h0, `WWD_OFS_COUNT, 32'h0);
    chk("count reset", 32'h3F, q);
    xfer(1'h0, `WWD_OFS_RELOAD, 32'h0);
    chk("reload read", 32'h0, q);
    xfer(1'h0, 5'h14, 32'h0);
    chk("unmapped", 32'h0, q);
    xfer(1'h1, `WWD_OFS_CTRL, 32'h0010_0001);
    xfer(1'h1, `WWD_OFS_RELOAD, `WWD_RELOAD_KEY);
    @(posedge clk);
    chk("early key", 32'h1, wrst);
    complete_run;
  end

  // hang guard, about twice the expected run
  initial begin
    repeat (60000) @(posedge clk);
    n_errors++;
    complete_run;
  end
endmodule
